// ### inc/mcuie_defs.vh
// opcode codes, memory map limits and cycle counts of the execution unit
`ifndef MCUIE_DEFS_VH
`define MCUIE_DEFS_VH

// ****************************************
// opcodes (bank-zero forms share the plain codes, except the bank-zero move-immediate)
// ****************************************
`define MCUIE_OP_NOP        6'h00
`define MCUIE_OP_MOV_AM     6'h01
`define MCUIE_OP_MOV_MA     6'h02
`define MCUIE_OP_MOV_AI     6'h03
`define MCUIE_OP_B0MOVE_MI  6'h04
`define MCUIE_OP_EXCHANGE   6'h05
`define MCUIE_OP_ADC_AM     6'h06
`define MCUIE_OP_ADC_MA     6'h07
`define MCUIE_OP_ADD_AM     6'h08
`define MCUIE_OP_ADD_MA     6'h09
`define MCUIE_OP_ADD_AI     6'h0A
`define MCUIE_OP_SUBB_AM    6'h0B
`define MCUIE_OP_SUBB_MA    6'h0C
`define MCUIE_OP_SUB_AM     6'h0D
`define MCUIE_OP_SUB_MA     6'h0E
`define MCUIE_OP_SUB_AI     6'h0F
`define MCUIE_OP_AND_AM     6'h10
`define MCUIE_OP_AND_MA     6'h11
`define MCUIE_OP_AND_AI     6'h12
`define MCUIE_OP_OR_AM      6'h13
`define MCUIE_OP_OR_MA      6'h14
`define MCUIE_OP_OR_AI      6'h15
`define MCUIE_OP_XOR_AM     6'h16
`define MCUIE_OP_XOR_MA     6'h17
`define MCUIE_OP_XOR_AI     6'h18
`define MCUIE_OP_SWAP_A     6'h19
`define MCUIE_OP_SWAP_M     6'h1A
`define MCUIE_OP_ROTR_A     6'h1B
`define MCUIE_OP_ROTR_M     6'h1C
`define MCUIE_OP_ROTL_A     6'h1D
`define MCUIE_OP_ROTL_M     6'h1E
`define MCUIE_OP_CLR        6'h1F
`define MCUIE_OP_BITCLR     6'h20
`define MCUIE_OP_BITSET     6'h21
`define MCUIE_OP_CMPS_AI    6'h22
`define MCUIE_OP_CMPS_AM    6'h23
`define MCUIE_OP_INCREMENT_SKIP_ZERO_A     6'h24
`define MCUIE_OP_INCREMENT_SKIP_ZERO_M     6'h25
`define MCUIE_OP_DECREMENT_SKIP_ZERO_A     6'h26
`define MCUIE_OP_DECREMENT_SKIP_ZERO_M     6'h27
`define MCUIE_OP_BTST0      6'h28
`define MCUIE_OP_BTST1      6'h29
`define MCUIE_OP_PJUMP      6'h2A
`define MCUIE_OP_CALL       6'h2B
`define MCUIE_OP_SRETURN    6'h2C
`define MCUIE_OP_IRETURN    6'h2D
`define MCUIE_OP_PUSH       6'h2E
`define MCUIE_OP_POP        6'h2F

// ****************************************
// memory map and timing
// ****************************************
`define MCUIE_SYSREG_BASE   8'h80
`define MCUIE_IMM_REG_LAST  8'h87
`define MCUIE_BRANCH_CYCLES 2'h2
`define MCUIE_RESET_PC      16'h0000

`endif

// ### hdl/mcuie_data_ram.v
// data memory: asynchronous read, synchronous write
`timescale 1ns/10ps
`default_nettype none

module mcuie_data_ram #(
  parameter AW = 8,
  parameter DW = 8
) (
  input  wire          core_clk,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire [AW-1:0] rd_addr,
  output wire [DW-1:0] rd_data
);

  // ****************************************
  // storage
  // ****************************************
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // write port
  always @(posedge core_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  assign rd_data = mem[rd_addr];

endmodule // mcuie_data_ram

`default_nettype wire

// ### hdl/mcuie_exec.v
// instruction execution unit of the 8-bit core
// What this block does
// RQ1: the bank-zero move-immediate form writes only addresses 0x80 to 0x87 and is dropped elsewhere.
// RQ2: add and add-with-carry set carry on an 8-bit overflow and clear it otherwise.
// RQ3: subtract and subtract-with-borrow clear carry on a borrow and set it when there is none.
// RQ4: subtract-with-borrow takes accumulator minus operand minus inverted carry and updates C, DC, Z.
// RQ5: bank-zero add-to-memory writes accumulator plus memory back to memory and sets carry from the 8-bit overflow.
// RQ6: a write-back costs no extra cycle to a system register and one extra to general RAM, except move-to-memory and clear, which cost none.
// RQ7: every conditional skip costs one extra cycle when its condition holds.
// RQ8: compare-and-skip updates Z and C from accumulator minus operand and skips on equality.
// RQ9: increment/decrement-and-skip write the result, skip on zero and keep the flags.
// RQ10: bit tests skip when the chosen bit is 0 for the zero form or 1 for the one form.
// RQ11: jump and call load PC from the page bits and the 14-bit target in two cycles; call pushes PC plus one.
// RQ12: returns pop PC in two cycles and the interrupt return re-enables global interrupts.
// RQ13: save-context copies accumulator and C, DC, Z into shadow buffers in one cycle.
// RQ14: restore-context reloads accumulator and C, DC, Z from the shadow buffers.
// RQ15: nibble swap exchanges the nibbles of a memory byte into A or memory and keeps the flags.
// RQ16: rotates go through carry into A or memory and update only carry.
// RQ17: AND, OR and XOR update only zero, and memory forms pay the write-back cost.
`timescale 1ns/10ps
`default_nettype none
`include "mcuie_defs.vh"

module mcuie_exec #(
  parameter STACK_DEPTH = 8
) (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        instr_valid,
  input  wire [5:0]  instr_op,
  input  wire [7:0]  instr_addr,
  input  wire [7:0]  instr_imm,
  input  wire [2:0]  instr_bit,
  input  wire [13:0] instr_target,
  input  wire [1:0]  rom_page_select_bits,
  output reg         instr_ready_reg,
  output reg         retire_reg,
  output reg         skip_taken_reg,
  output reg  [1:0]  cycles_used_reg,
  output reg  [15:0] pc_reg,
  output reg  [7:0]  accumulator_register,
  output reg         carry_flag_reg,
  output reg         digit_carry_flag,
  output reg         zero_flag_reg,
  output reg         global_int_en_reg,
  output reg         stack_fault_reg
);

  // ****************************************
  // arithmetic helper: returns {carry, digit carry, sum}
  // ****************************************
  function [9:0] add8;
    input [7:0] a;
    input [7:0] b;
    input       cin;
    reg   [4:0] lo;
    reg   [4:0] hi;
    begin
      lo    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      hi    = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
      add8  = {hi[4], lo[4], hi[3:0], lo[3:0]};
    end
  endfunction

  localparam SP_W = $clog2(STACK_DEPTH) + 1;

  // ****************************************
  // state
  // ****************************************
  reg  [15:0]     stack_mem [0:STACK_DEPTH-1];
  reg  [SP_W-1:0] sp_reg;
  reg  [1:0]      wait_reg;
  reg  [7:0]      shadow_acc_reg;
  reg  [2:0]      shadow_flags_reg;
  wire [7:0]      mem_rd;
  wire            accept = instr_valid & instr_ready_reg;

  // ****************************************
  // execute decode
  // ****************************************
  reg  [7:0]  res_next;
  reg         wr_a_next;
  reg         wr_m_next;
  reg         upd_c;
  reg         upd_dc;
  reg         upd_z;
  reg         c_next;
  reg         dc_next;
  reg         skip_next;
  reg         branch_next;
  reg  [9:0]  alu;
  reg  [7:0]  opnd;
  wire        is_ram = (instr_addr < `MCUIE_SYSREG_BASE);
  wire [7:0]  bit_mask = 8'h01 << instr_bit;

  always @*
  begin
    res_next    = 8'h00;
    wr_a_next   = 1'b0;
    wr_m_next   = 1'b0;
    upd_c       = 1'b0;
    upd_dc      = 1'b0;
    upd_z       = 1'b0;
    skip_next   = 1'b0;
    branch_next = 1'b0;
    opnd        = mem_rd;
    alu         = 10'h000;
    case (instr_op)
      `MCUIE_OP_ADD_AI, `MCUIE_OP_SUB_AI, `MCUIE_OP_AND_AI, `MCUIE_OP_OR_AI,
      `MCUIE_OP_XOR_AI, `MCUIE_OP_CMPS_AI, `MCUIE_OP_MOV_AI, `MCUIE_OP_B0MOVE_MI:
        opnd = instr_imm;
      default:
        opnd = mem_rd;
    endcase
    case (instr_op)
      // add family: carry out of bit 7
      `MCUIE_OP_ADC_AM, `MCUIE_OP_ADC_MA:
        alu = add8(accumulator_register, opnd, carry_flag_reg); // RQ2
      `MCUIE_OP_ADD_AM, `MCUIE_OP_ADD_MA, `MCUIE_OP_ADD_AI:
        alu = add8(accumulator_register, opnd, 1'b0); // RQ2 RQ5
      // subtract as A + ~M + cin, so carry out is the inverted borrow
      `MCUIE_OP_SUBB_AM, `MCUIE_OP_SUBB_MA:
        alu = add8(accumulator_register, ~opnd, carry_flag_reg); // RQ3 RQ4
      `MCUIE_OP_SUB_AM, `MCUIE_OP_SUB_MA, `MCUIE_OP_SUB_AI,
      `MCUIE_OP_CMPS_AI, `MCUIE_OP_CMPS_AM:
        alu = add8(accumulator_register, ~opnd, 1'b1); // RQ3 RQ8
      default:
        alu = 10'h000;
    endcase
    c_next  = alu[9];
    dc_next = alu[8];
    case (instr_op)
      `MCUIE_OP_MOV_AM, `MCUIE_OP_MOV_AI:
      begin
        res_next  = opnd;
        wr_a_next = 1'b1;
      end
      `MCUIE_OP_MOV_MA:
      begin
        res_next  = accumulator_register;
        wr_m_next = 1'b1;
      end
      `MCUIE_OP_B0MOVE_MI:
      begin
        res_next  = opnd;
        wr_m_next = (instr_addr >= `MCUIE_SYSREG_BASE) &&
                    (instr_addr <= `MCUIE_IMM_REG_LAST); // RQ1
      end
      `MCUIE_OP_EXCHANGE:
      begin
        res_next  = accumulator_register;
        wr_m_next = 1'b1;
        wr_a_next = 1'b1;
      end
      `MCUIE_OP_ADC_AM, `MCUIE_OP_ADD_AM, `MCUIE_OP_ADD_AI, `MCUIE_OP_SUBB_AM,
      `MCUIE_OP_SUB_AM, `MCUIE_OP_SUB_AI:
      begin
        res_next  = alu[7:0];
        wr_a_next = 1'b1;
        {upd_c, upd_dc, upd_z} = 3'b111;
      end
      `MCUIE_OP_ADC_MA, `MCUIE_OP_ADD_MA, `MCUIE_OP_SUBB_MA, `MCUIE_OP_SUB_MA:
      begin
        res_next  = alu[7:0];
        wr_m_next = 1'b1; // RQ5
        {upd_c, upd_dc, upd_z} = 3'b111;
      end
      `MCUIE_OP_AND_AM, `MCUIE_OP_AND_AI, `MCUIE_OP_AND_MA:
      begin
        res_next  = accumulator_register & opnd;
        upd_z     = 1'b1; // RQ17
        wr_m_next = (instr_op == `MCUIE_OP_AND_MA);
        wr_a_next = !wr_m_next;
      end
      `MCUIE_OP_OR_AM, `MCUIE_OP_OR_AI, `MCUIE_OP_OR_MA:
      begin
        res_next  = accumulator_register | opnd;
        upd_z     = 1'b1; // RQ17
        wr_m_next = (instr_op == `MCUIE_OP_OR_MA);
        wr_a_next = !wr_m_next;
      end
      `MCUIE_OP_XOR_AM, `MCUIE_OP_XOR_AI, `MCUIE_OP_XOR_MA:
      begin
        res_next  = accumulator_register ^ opnd;
        upd_z     = 1'b1; // RQ17
        wr_m_next = (instr_op == `MCUIE_OP_XOR_MA);
        wr_a_next = !wr_m_next;
      end
      `MCUIE_OP_SWAP_A, `MCUIE_OP_SWAP_M:
      begin
        res_next  = {opnd[3:0], opnd[7:4]}; // RQ15
        wr_m_next = (instr_op == `MCUIE_OP_SWAP_M);
        wr_a_next = !wr_m_next;
      end
      `MCUIE_OP_ROTR_A, `MCUIE_OP_ROTR_M:
      begin
        res_next  = {carry_flag_reg, opnd[7:1]}; // RQ16
        c_next    = opnd[0];
        upd_c     = 1'b1;
        wr_m_next = (instr_op == `MCUIE_OP_ROTR_M);
        wr_a_next = !wr_m_next;
      end
      `MCUIE_OP_ROTL_A, `MCUIE_OP_ROTL_M:
      begin
        res_next  = {opnd[6:0], carry_flag_reg}; // RQ16
        c_next    = opnd[7];
        upd_c     = 1'b1;
        wr_m_next = (instr_op == `MCUIE_OP_ROTL_M);
        wr_a_next = !wr_m_next;
      end
      `MCUIE_OP_CLR:
        wr_m_next = 1'b1;
      `MCUIE_OP_BITCLR:
      begin
        res_next  = opnd & ~bit_mask;
        wr_m_next = 1'b1;
      end
      `MCUIE_OP_BITSET:
      begin
        res_next  = opnd | bit_mask;
        wr_m_next = 1'b1;
      end
      `MCUIE_OP_CMPS_AI, `MCUIE_OP_CMPS_AM:
      begin
        {upd_c, upd_z} = 2'b11; // RQ8
        skip_next = (accumulator_register == opnd); // RQ8
      end
      `MCUIE_OP_INCREMENT_SKIP_ZERO_A, `MCUIE_OP_INCREMENT_SKIP_ZERO_M, `MCUIE_OP_DECREMENT_SKIP_ZERO_A, `MCUIE_OP_DECREMENT_SKIP_ZERO_M:
      begin
        if ((instr_op == `MCUIE_OP_INCREMENT_SKIP_ZERO_A) || (instr_op == `MCUIE_OP_INCREMENT_SKIP_ZERO_M))
          res_next = opnd + 8'h01; // RQ9
        else
          res_next = opnd - 8'h01; // RQ9
        skip_next = (res_next == 8'h00); // RQ9
        wr_m_next = (instr_op == `MCUIE_OP_INCREMENT_SKIP_ZERO_M) || (instr_op == `MCUIE_OP_DECREMENT_SKIP_ZERO_M);
        wr_a_next = !wr_m_next;
      end
      `MCUIE_OP_BTST0:
        skip_next = ((opnd & bit_mask) == 8'h00); // RQ10
      `MCUIE_OP_BTST1:
        skip_next = ((opnd & bit_mask) != 8'h00); // RQ10
      `MCUIE_OP_PJUMP, `MCUIE_OP_CALL, `MCUIE_OP_SRETURN, `MCUIE_OP_IRETURN:
        branch_next = 1'b1;
      default:
        res_next = 8'h00;
    endcase
  end

  // ****************************************
  // cycle cost of the accepted instruction
  // ****************************************
  wire       pays_n  = wr_m_next && instr_op != `MCUIE_OP_MOV_MA && instr_op != `MCUIE_OP_CLR;
  wire [1:0] extra_n = (pays_n && is_ram) ? 2'h1 : 2'h0; // RQ6
  wire [1:0] extra_s = skip_next ? 2'h1 : 2'h0;             // RQ7
  wire [1:0] cost    = branch_next ? `MCUIE_BRANCH_CYCLES :
                       (2'h1 + extra_n + extra_s); // RQ11 RQ12

  mcuie_data_ram #(
    .AW (8),
    .DW (8)
  ) u_ram (
    .core_clk (core_clk),
    .wr_en    (accept & wr_m_next),
    .wr_addr  (instr_addr),
    .wr_data  (res_next),
    .rd_addr  (instr_addr),
    .rd_data  (mem_rd)
  );

  // ****************************************
  // commit on accept, then hold off for the remaining cycles
  // ****************************************
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      instr_ready_reg      <= 1'b1;
      retire_reg           <= 1'b0;
      skip_taken_reg       <= 1'b0;
      cycles_used_reg      <= 2'h0;
      pc_reg               <= `MCUIE_RESET_PC;
      accumulator_register <= 8'h00;
      carry_flag_reg       <= 1'b0;
      digit_carry_flag     <= 1'b0;
      zero_flag_reg        <= 1'b0;
      global_int_en_reg    <= 1'b0;
      stack_fault_reg      <= 1'b0;
      sp_reg               <= {SP_W{1'b0}};
      wait_reg             <= 2'h0;
      shadow_acc_reg       <= 8'h00;
      shadow_flags_reg     <= 3'h0;
    end
    else if (accept)
    begin
      cycles_used_reg <= cost;
      skip_taken_reg  <= skip_next;
      wait_reg        <= cost - 2'h1;
      instr_ready_reg <= (cost == 2'h1);
      retire_reg      <= (cost == 2'h1);
      pc_reg          <= pc_reg + (skip_next ? 16'h0002 : 16'h0001);
      if (wr_a_next)
        accumulator_register <= (instr_op == `MCUIE_OP_EXCHANGE) ? mem_rd : res_next;
      if (upd_c)
        carry_flag_reg <= c_next;
      if (upd_dc)
        digit_carry_flag <= dc_next;
      if (upd_z)
        zero_flag_reg <= (instr_op == `MCUIE_OP_CMPS_AI || instr_op == `MCUIE_OP_CMPS_AM) ?
                         (alu[7:0] == 8'h00) : (res_next == 8'h00);
      case (instr_op)
        `MCUIE_OP_PJUMP:
          pc_reg <= {rom_page_select_bits, instr_target}; // RQ11
        `MCUIE_OP_CALL:
        begin
          pc_reg <= {rom_page_select_bits, instr_target}; // RQ11
          if (sp_reg < STACK_DEPTH)
          begin
            stack_mem[sp_reg[SP_W-2:0]] <= pc_reg + 16'h0001; // RQ11
            sp_reg <= sp_reg + {{(SP_W-1){1'b0}}, 1'b1};
          end
          else
            stack_fault_reg <= 1'b1;
        end
        `MCUIE_OP_SRETURN, `MCUIE_OP_IRETURN:
        begin
          if (sp_reg != {SP_W{1'b0}})
          begin
            pc_reg <= stack_mem[sp_reg[SP_W-2:0] - 1'b1]; // RQ12
            sp_reg <= sp_reg - {{(SP_W-1){1'b0}}, 1'b1};
          end
          else
            stack_fault_reg <= 1'b1;
          if (instr_op == `MCUIE_OP_IRETURN)
            global_int_en_reg <= 1'b1; // RQ12
        end
        `MCUIE_OP_PUSH:
        begin
          shadow_acc_reg   <= accumulator_register; // RQ13
          shadow_flags_reg <= {zero_flag_reg, digit_carry_flag, carry_flag_reg}; // RQ13
        end
        `MCUIE_OP_POP:
        begin
          accumulator_register <= shadow_acc_reg; // RQ14
          zero_flag_reg        <= shadow_flags_reg[2]; // RQ14
          digit_carry_flag     <= shadow_flags_reg[1];
          carry_flag_reg       <= shadow_flags_reg[0];
        end
        default:
          stack_fault_reg <= stack_fault_reg;
      endcase
    end
    else
    begin
      // count out extra cycles of a multi-cycle instruction
      retire_reg <= (wait_reg == 2'h1);
      if (wait_reg != 2'h0)
        wait_reg <= wait_reg - 2'h1;
      instr_ready_reg <= (wait_reg <= 2'h1);
    end
  end

endmodule // mcuie_exec

`default_nettype wire

// ### verif/mcuie_exec_sva.sv
// concurrent assertions on the ports of the instruction execution unit
`timescale 1ns/10ps
`default_nettype none
`include "mcuie_defs.vh"

module mcuie_exec_sva #(
  parameter STACK_DEPTH = 8
) (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        instr_valid,
  input wire logic [5:0]  instr_op,
  input wire logic [7:0]  instr_addr,
  input wire logic [7:0]  instr_imm,
  input wire logic [2:0]  instr_bit,
  input wire logic [13:0] instr_target,
  input wire logic [1:0]  rom_page_select_bits,
  input wire logic        instr_ready_reg,
  input wire logic        retire_reg,
  input wire logic        skip_taken_reg,
  input wire logic [1:0]  cycles_used_reg,
  input wire logic [15:0] pc_reg,
  input wire logic [7:0]  accumulator_register,
  input wire logic        carry_flag_reg,
  input wire logic        digit_carry_flag,
  input wire logic        zero_flag_reg,
  input wire logic        global_int_en_reg,
  input wire logic        stack_fault_reg
);
  // ****************************************
  // accept strobe and opcode groups
  // ****************************************
  wire logic acc = instr_valid && instr_ready_reg;
  wire logic br  = instr_op >= `MCUIE_OP_PJUMP && instr_op <= `MCUIE_OP_IRETURN;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_one_cycle: assert property (acc ##1 cycles_used_reg == 2'h1 |-> instr_ready_reg && retire_reg)
    else $error("one cycle op not retired at once");
  a_two_cycle: assert property (acc ##1 cycles_used_reg == 2'h2 |->
    !instr_ready_reg && !retire_reg ##1 instr_ready_reg && retire_reg)
    else $error("two cycle op has wrong busy span");
  a_three_cycle: assert property (acc ##1 cycles_used_reg == 2'h3 |->
    (!instr_ready_reg && !retire_reg) [*2] ##1 instr_ready_reg && retire_reg)
    else $error("three cycle op has wrong busy span");
  a_skip_cost: assert property (acc |=> !skip_taken_reg || cycles_used_reg >= 2'h2)
    else $error("taken skip without extra cycle");
  a_pc_step: assert property (acc && !br |=>
    pc_reg == $past(pc_reg) + (skip_taken_reg ? 16'h0002 : 16'h0001))
    else $error("pc step does not match skip");
  a_jump_load: assert property (acc && instr_op == `MCUIE_OP_PJUMP |=>
    pc_reg == {$past(rom_page_select_bits), $past(instr_target)} && cycles_used_reg == 2'h2)
    else $error("jump target or cost wrong");
  a_skip_flags: assert property (acc && instr_op >= `MCUIE_OP_INCREMENT_SKIP_ZERO_A && instr_op <= `MCUIE_OP_DECREMENT_SKIP_ZERO_M
    |=> $stable(carry_flag_reg) && $stable(zero_flag_reg) && $stable(digit_carry_flag))
    else $error("inc or dec skip changed flags");
  a_logic_carry: assert property (acc && instr_op >= `MCUIE_OP_AND_AM && instr_op <= `MCUIE_OP_XOR_AI
    |=> $stable(carry_flag_reg) && $stable(digit_carry_flag))
    else $error("logic op changed carry");
  a_swap_flags: assert property (acc && (instr_op == `MCUIE_OP_SWAP_A || instr_op == `MCUIE_OP_SWAP_M)
    |=> $stable(carry_flag_reg) && $stable(zero_flag_reg) && $stable(digit_carry_flag))
    else $error("nibble swap changed flags");
  a_iret_enable: assert property (acc && instr_op == `MCUIE_OP_IRETURN |=>
    global_int_en_reg || stack_fault_reg)
    else $error("interrupt return left interrupts off");
endmodule // mcuie_exec_sva

bind mcuie_exec mcuie_exec_sva #(.STACK_DEPTH(STACK_DEPTH)) u_sva (.core_clk, .reset,
  .instr_valid, .instr_op, .instr_addr, .instr_imm, .instr_bit, .instr_target,
  .rom_page_select_bits, .instr_ready_reg, .retire_reg, .skip_taken_reg, .cycles_used_reg,
  .pc_reg, .accumulator_register, .carry_flag_reg, .digit_carry_flag, .zero_flag_reg,
  .global_int_en_reg, .stack_fault_reg);
`default_nettype wire

// ### verif/mcuie_exec_test.sv
// self-checking testbench of the instruction execution unit
`timescale 1ns/10ps
`default_nettype none
`include "mcuie_defs.vh"

module mcuie_exec_test;
  reg         core_clk, reset, instr_valid;
  reg  [5:0]  instr_op, op;
  reg  [7:0]  instr_addr, instr_imm, ad;
  reg  [2:0]  instr_bit;
  reg  [13:0] instr_target;
  reg  [1:0]  rom_page_select_bits;
  wire        instr_ready_reg, retire_reg, skip_taken_reg, carry_flag_reg, digit_carry_flag;
  wire        zero_flag_reg, global_int_en_reg, stack_fault_reg;
  wire [1:0]  cycles_used_reg;
  wire [15:0] pc_reg;
  wire [7:0]  accumulator_register;
  // reference state
  reg  [7:0]  mem [0:255];
  reg  [15:0] stk [0:7];
  reg  [15:0] m_pc;
  reg  [7:0]  m_a, sh_a;
  reg  [31:0] rnd;
  reg         m_c, m_dc, m_z, z_ok, dc_ok, m_gie, sh_c, sh_dc, sh_z, sh_zok, sh_dcok;
  integer     sp, failures, samples_checked, seed, i;

  mcuie_exec #(.STACK_DEPTH(8)) dut (.core_clk, .reset, .instr_valid, .instr_op, .instr_addr,
    .instr_imm, .instr_bit, .instr_target, .rom_page_select_bits, .instr_ready_reg, .retire_reg,
    .skip_taken_reg, .cycles_used_reg, .pc_reg, .accumulator_register, .carry_flag_reg,
    .digit_carry_flag, .zero_flag_reg, .global_int_en_reg, .stack_fault_reg);

  // ****************************************
  // clock, compare and verdict
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task check(input [31:0] seen, input [31:0] exp, input [8*8-1:0] what);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("Error %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task give_verdict;
    begin
      if (failures == 0 && samples_checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // hold reset five cycles, check reset values, release
  task do_reset;
    begin
      repeat (5) @(negedge core_clk);
      check({instr_ready_reg, retire_reg, skip_taken_reg, carry_flag_reg, digit_carry_flag,
             zero_flag_reg, global_int_en_reg, stack_fault_reg}, 32'h80, "rststat");
      check({pc_reg, accumulator_register, cycles_used_reg}, 32'h0, "rstval");
      reset = 1'b0;
      m_a = 8'h00; m_c = 1'b0; m_dc = 1'b0; m_z = 1'b0; z_ok = 1'b1; dc_ok = 1'b1;
      m_pc = 16'h0000; sp = 0; m_gie = 1'b0;
    end
  endtask

  // ****************************************
  // one instruction: predict, issue, compare
  // ****************************************
  task run(input [5:0] c, input [7:0] a, input [7:0] im, input [2:0] bt, input [13:0] tg);
    reg [8:0] r;
    reg [4:0] q;
    reg [7:0] m, o, res;
    reg       wr, sk, s, sb;
    integer   k, n;
    begin
      m = mem[a]; o = (c == `MCUIE_OP_ADD_AI || c == `MCUIE_OP_SUB_AI || c == `MCUIE_OP_CMPS_AI
        || c == 6'h12 || c == 6'h15 || c == 6'h18) ? im : m;
      wr = 1'b0; sk = 1'b0; res = m; k = 1;
      s = (c == `MCUIE_OP_SUBB_AM || c == `MCUIE_OP_SUBB_MA);
      case (c)
        `MCUIE_OP_MOV_AI: m_a = im;
        `MCUIE_OP_MOV_AM: begin m_a = m; z_ok = 1'b0; end
        `MCUIE_OP_MOV_MA: mem[a] = m_a;
        `MCUIE_OP_B0MOVE_MI: if (a >= 8'h80 && a <= 8'h87) mem[a] = im;
        `MCUIE_OP_CLR: mem[a] = 8'h00;
        `MCUIE_OP_EXCHANGE: begin res = m_a; m_a = m; wr = 1'b1; end
        `MCUIE_OP_ADD_AM, `MCUIE_OP_ADD_MA, `MCUIE_OP_ADD_AI, `MCUIE_OP_ADC_AM, `MCUIE_OP_ADC_MA:
        begin
          sb = (c == `MCUIE_OP_ADC_AM || c == `MCUIE_OP_ADC_MA) & m_c;
          r = {1'b0, m_a} + {1'b0, o} + {8'h00, sb};
          m_c = r[8]; z_ok = 1'b0; dc_ok = 1'b0;
          if (c == `MCUIE_OP_ADD_MA || c == `MCUIE_OP_ADC_MA) begin res = r[7:0]; wr = 1'b1; end
          else m_a = r[7:0];
        end
        `MCUIE_OP_SUB_AM, `MCUIE_OP_SUB_MA, `MCUIE_OP_SUB_AI, `MCUIE_OP_SUBB_AM, `MCUIE_OP_SUBB_MA:
        begin
          sb = s & ~m_c;
          r = {1'b0, m_a} - {1'b0, o} - {8'h00, sb};
          q = {1'b0, m_a[3:0]} - {1'b0, o[3:0]} - {4'h0, sb};
          m_c = ~r[8]; m_dc = ~q[4]; m_z = (r[7:0] == 8'h00); z_ok = 1'b1; dc_ok = 1'b1;
          if (c == `MCUIE_OP_SUB_MA || c == `MCUIE_OP_SUBB_MA) begin res = r[7:0]; wr = 1'b1; end
          else m_a = r[7:0];
        end
        `MCUIE_OP_SWAP_A, `MCUIE_OP_SWAP_M, `MCUIE_OP_ROTR_A, `MCUIE_OP_ROTR_M,
        `MCUIE_OP_ROTL_A, `MCUIE_OP_ROTL_M:
        begin
          if (c <= `MCUIE_OP_SWAP_M) res = {m[3:0], m[7:4]};
          else if (c <= `MCUIE_OP_ROTR_M) begin res = {m_c, m[7:1]}; m_c = m[0]; end
          else begin res = {m[6:0], m_c}; m_c = m[7]; end
          if (c[0]) m_a = res; else wr = 1'b1;
        end
        `MCUIE_OP_BITCLR, `MCUIE_OP_BITSET: begin res[bt] = c[0]; wr = 1'b1; end
        `MCUIE_OP_CMPS_AI, `MCUIE_OP_CMPS_AM:
        begin
          r = {1'b0, m_a} - {1'b0, o};
          m_c = ~r[8]; m_z = (r[7:0] == 8'h00); z_ok = 1'b1; sk = m_z;
        end
        `MCUIE_OP_INCREMENT_SKIP_ZERO_A, `MCUIE_OP_INCREMENT_SKIP_ZERO_M, `MCUIE_OP_DECREMENT_SKIP_ZERO_A, `MCUIE_OP_DECREMENT_SKIP_ZERO_M:
        begin
          res = c[1] ? m - 8'h01 : m + 8'h01; sk = (res == 8'h00);
          if (c[0]) wr = 1'b1; else m_a = res;
        end
        `MCUIE_OP_BTST0, `MCUIE_OP_BTST1: sk = (m[bt] == c[0]);
        `MCUIE_OP_PJUMP, `MCUIE_OP_CALL:
        begin
          if (c[0]) begin stk[sp] = m_pc + 16'h0001; sp = sp + 1; end
          m_pc = {rom_page_select_bits, tg}; k = 2;
        end
        `MCUIE_OP_SRETURN, `MCUIE_OP_IRETURN:
        begin
          sp = sp - 1; m_pc = stk[sp]; k = 2;
          if (c[0]) m_gie = 1'b1;
        end
        `MCUIE_OP_PUSH: begin sh_a = m_a; sh_c = m_c; sh_dc = m_dc; sh_z = m_z;
          sh_zok = z_ok; sh_dcok = dc_ok; end
        `MCUIE_OP_POP: begin m_a = sh_a; m_c = sh_c; m_dc = sh_dc; m_z = sh_z;
          z_ok = sh_zok; dc_ok = sh_dcok; end
        default:
          if (c >= `MCUIE_OP_AND_AM && c <= `MCUIE_OP_XOR_AI)
          begin
            r = (c <= 6'h12) ? m_a & o : (c <= 6'h15) ? m_a | o : m_a ^ o;
            m_z = (r[7:0] == 8'h00); z_ok = 1'b1;
            if (c == 6'h11 || c == 6'h14 || c == 6'h17) begin res = r[7:0]; wr = 1'b1; end
            else m_a = r[7:0];
          end
      endcase
      if (wr) begin mem[a] = res; if (a < 8'h80) k = k + 1; end
      if (sk) k = k + 1;
      if (k == 1 || sk || wr) m_pc = m_pc + (sk ? 16'h0002 : 16'h0001);
      instr_op = c; instr_addr = a; instr_imm = im; instr_bit = bt; instr_target = tg;
      instr_valid = 1'b1;
      @(negedge core_clk);
      check(accumulator_register, m_a, "acc");
      check(carry_flag_reg, m_c, "carry");
      if (z_ok) check(zero_flag_reg, m_z, "zero");
      if (dc_ok) check(digit_carry_flag, m_dc, "dcarry");
      check(pc_reg, m_pc, "pc");
      check({skip_taken_reg, cycles_used_reg}, {sk, k[1:0]}, "cost");
      check({global_int_en_reg, stack_fault_reg}, {m_gie, 1'b0}, "gie");
      n = 1;
      while (instr_ready_reg !== 1'b1 && n < 8) begin @(negedge core_clk); n = n + 1; end
      check({n[2:0], retire_reg}, {k[2:0], 1'b1}, "retire");
    end
  endtask

  task d(input [5:0] c, input [7:0] a, input [7:0] im);
    run(c, a, im, 3'h0, 14'h0000);
  endtask

  // watchdog against a hang
  initial
  begin
    #800000;
    failures = failures + 1;
    give_verdict;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    seed = 4623; failures = 0; samples_checked = 0;
    reset = 1'b1; instr_valid = 1'b0; instr_op = 6'h00; instr_addr = 8'h00; instr_imm = 8'h00;
    instr_bit = 3'h0; instr_target = 14'h0000; rom_page_select_bits = 2'h0;
    do_reset;
    for (i = 0; i < 4; i = i + 1)
    begin
      rnd = $random(seed);
      d(`MCUIE_OP_MOV_AI, 8'h00, rnd[7:0]);
      d(`MCUIE_OP_MOV_MA, 8'h10 + i[7:0], 8'h00);
      d(`MCUIE_OP_MOV_MA, 8'h80 + i[7:0], 8'h00);
    end
    d(`MCUIE_OP_PUSH, 8'h00, 8'h00);
    for (i = 0; i < 300; i = i + 1)
    begin
      rnd = $random(seed);
      op = rnd % 48;
      if ((op == `MCUIE_OP_SRETURN || op == `MCUIE_OP_IRETURN) && sp == 0) op = `MCUIE_OP_CALL;
      if (op == `MCUIE_OP_CALL && sp == 8) op = `MCUIE_OP_SRETURN;
      ad = (rnd[8] ? 8'h80 : 8'h10) + {6'h00, rnd[10:9]};
      rom_page_select_bits = rnd[12:11];
      rnd = $random(seed);
      run(op, ad, rnd[7:0], rnd[10:8], rnd[24:11]);
      d(`MCUIE_OP_MOV_AM, ad, 8'h00);
    end
    // second reset in mid-run, then corner cases
    instr_valid = 1'b0;
    reset = 1'b1;
    do_reset;
    d(`MCUIE_OP_MOV_AI, 8'h00, 8'hFF);
    d(`MCUIE_OP_ADD_AI, 8'h00, 8'h01);
    d(`MCUIE_OP_SUB_AI, 8'h00, 8'h01);
    d(`MCUIE_OP_MOV_MA, 8'h10, 8'h00);
    d(`MCUIE_OP_MOV_MA, 8'h88, 8'h00);
    d(`MCUIE_OP_INCREMENT_SKIP_ZERO_M, 8'h10, 8'h00);
    d(`MCUIE_OP_DECREMENT_SKIP_ZERO_M, 8'h10, 8'h00);
    d(`MCUIE_OP_B0MOVE_MI, 8'h87, 8'h5A);
    d(`MCUIE_OP_B0MOVE_MI, 8'h88, 8'hA5);
    d(`MCUIE_OP_MOV_AM, 8'h87, 8'h00);
    d(`MCUIE_OP_MOV_AM, 8'h88, 8'h00);
    d(`MCUIE_OP_CMPS_AI, 8'h00, 8'hFF);
    d(`MCUIE_OP_CALL, 8'h00, 8'h00);
    d(`MCUIE_OP_IRETURN, 8'h00, 8'h00);
    instr_valid = 1'b0;
    repeat (3) @(negedge core_clk);
    give_verdict;
  end
endmodule // mcuie_exec_test
`default_nettype wire
